// ==== pid_selector_defs.svh ====
// register offsets, field codes and timing counts of the pid selector
// assumes inclusion from the design file and the bench by bare name
`ifndef PID_SELECTOR_DEFS_SVH
`define PID_SELECTOR_DEFS_SVH

`define MCLK_PERIOD_NS 10
`define CTRL_PERIOD_NS 1000
`define CTRL_CYCLES ((`CTRL_PERIOD_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`define REG_MODE 8'h00
`define REG_PANEL_SP 8'h04
`define REG_RANGES 8'h08
`define REG_UPPER 8'h0c
`define REG_LOWER 8'h10
`define REG_INFUNC0 8'h14
`define REG_INFUNC1 8'h18
`define REG_OUTFUNC 8'h1c
`define REG_COMMSEL 8'h20
`define REG_BUS_DEV 8'h24
`define REG_BUS_SP 8'h28
`define REG_BUS_MEAS 8'h2c
`define REG_STATUS 8'h30
`define REG_MASK 8'h34
`define REG_FREQ 8'h38
`define REG_CFG 8'h3c

`define MODE_T_REV 8'h14
`define MODE_T_FWD 8'h15
`define MODE_D_REV 8'h32
`define MODE_D_FWD 8'h33
`define MODE_B_REV 8'h3c
`define MODE_B_FWD 8'h3d
`define MODE_RESET 8'h00

`define PCT_NONE 16'h270f
`define PCT_FULL 16'h03e8
`define IN_FN_PIDSEL 8'h0e
`define OUT_FN_LOWER 8'h0e
`define OUT_FN_UPPER 8'h0f
`define OUT_FN_ROT 8'h10
`define OUT_FN_PID 8'h2f
`define OUT_FN_NEG 8'h64
`define FN_RESET 8'h00

`define SP_RANGE_5V_A 4'h1
`define SP_RANGE_5V_B 4'hb
`define MEAS_RANGE_MA 4'h0
`define MEAS_RANGE_5V 4'h1
`define RANGES_RESET 8'h01

`define ST_UPPER 0
`define ST_LOWER 1
`define ST_PID 2
`define CFG_INTEG 0
`define CFG_DERIV 1

`endif

// ==== pid_selector_pkg.sv ====
// types shared by the pid selector
// does not include the defs header
package pid_selector_pkg;
  typedef logic signed [15:0] pct_t;
  typedef enum logic [2:0] {
    SRC_TERMINAL = 3'b001,
    SRC_PANEL = 3'b010,
    SRC_BUS = 3'b100
  } spsrc_t;
endpackage : pid_selector_pkg

// ==== pid_process_control_selector.sv ====
// pid / normal operation selector with set-point and measured-value routing
// assumes ADC samples arrive synchronous to mclk; digital pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "pid_selector_defs.svh"

module pid_process_control_selector
  import pid_selector_pkg::*;
#(
  parameter int NUM_IN = 7,
  parameter int NUM_OUT = 3,
  parameter int ADC_W = 10,
  parameter int CTRL_CYCLES = `CTRL_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_IN-1:0] inputTerminal,
  input wire logic runForward,
  input wire logic runReverse,
  input wire logic [ADC_W-1:0] setpointAdc,
  input wire logic [ADC_W-1:0] measuredAdc,
  output logic [NUM_OUT-1:0] outputTerminal,
  output logic pidActive,
  output logic signed [17:0] freqCmd,
  output logic irq
);

  initial begin
    if (NUM_IN < 1 || NUM_IN > 8 || NUM_OUT < 1 || NUM_OUT > 4)
      $error("terminal count out of range");
    if (ADC_W < 8 || ADC_W > 14 || CTRL_CYCLES < 1 || CTRL_CYCLES > 4096)
      $error("adc width or control period out of range");
  end

  logic [7:0] mode;
  pct_t panelSp, upperLim, lowerLim, busDev, busSp, busMeas;
  logic [3:0] spRange, measRange;
  logic [7:0] inFunc [NUM_IN];
  logic [7:0] outFunc [NUM_OUT];
  logic [NUM_IN-1:0] commSel;
  logic [1:0] pidCfg;
  logic [2:0] status, mask;

  // apb slave, zero wait states
  logic setup, wrEn, mapped;
  assign setup = psel && !penable;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      `REG_MODE, `REG_PANEL_SP, `REG_RANGES, `REG_UPPER, `REG_LOWER,
      `REG_INFUNC0, `REG_INFUNC1, `REG_OUTFUNC, `REG_COMMSEL, `REG_BUS_DEV,
      `REG_BUS_SP, `REG_BUS_MEAS, `REG_STATUS, `REG_MASK, `REG_FREQ,
      `REG_CFG: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;
  assign wrEn = psel && penable && pwrite && mapped;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mode <= `MODE_RESET;
      panelSp <= `PCT_NONE;
      upperLim <= `PCT_NONE;
      lowerLim <= `PCT_NONE;
      spRange <= 4'(`RANGES_RESET);
      measRange <= `MEAS_RANGE_MA;
      busDev <= '0;
      busSp <= '0;
      busMeas <= '0;
      commSel <= '0;
      pidCfg <= 2'h3;
      mask <= '0;
    end else if (wrEn) begin
      case (paddr)
        `REG_MODE: mode <= pwdata[7:0];
        `REG_PANEL_SP: panelSp <= pwdata[15:0];
        `REG_RANGES: begin
          spRange <= pwdata[3:0];
          measRange <= pwdata[11:8];
        end
        `REG_UPPER: upperLim <= pwdata[15:0];
        `REG_LOWER: lowerLim <= pwdata[15:0];
        `REG_COMMSEL: commSel <= pwdata[NUM_IN-1:0];
        `REG_BUS_DEV: busDev <= pwdata[15:0];
        `REG_BUS_SP: busSp <= pwdata[15:0];
        `REG_BUS_MEAS: busMeas <= pwdata[15:0];
        `REG_MASK: mask <= pwdata[2:0];
        `REG_CFG: pidCfg <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // function select bytes, four terminals to a word
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_infunc
      always_ff @(posedge mclk) begin
        if (!reset_n)
          inFunc[gi] <= `FN_RESET;
        else if (wrEn && paddr == ((gi < 4) ? `REG_INFUNC0 : `REG_INFUNC1))
          inFunc[gi] <= pwdata[(gi%4)*8 +: 8];
      end
    end
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_outfunc
      always_ff @(posedge mclk) begin
        if (!reset_n)
          outFunc[gi] <= `FN_RESET;
        else if (wrEn && paddr == `REG_OUTFUNC)
          outFunc[gi] <= pwdata[gi*8 +: 8];
      end
    end
  endgenerate

  // pin synchronisers
  logic [NUM_IN-1:0] inMeta, inSync;
  logic [1:0] runMeta, runSync;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      inMeta <= '0;
      inSync <= '0;
      runMeta <= '0;
      runSync <= '0;
    end else begin
      inMeta <= inputTerminal;
      inSync <= inMeta;
      runMeta <= {runReverse, runForward};
      runSync <= runMeta;
    end
  end

  // enable decision, purely combinational so any change lands next cycle
  logic [NUM_IN-1:0] selAssigned;
  logic modeOk, modeTerm, modeDev, modeBus, fwdAction, selOn, pidEnable;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_sel
      assign selAssigned[gi] = inFunc[gi] == `IN_FN_PIDSEL;
    end
  endgenerate
  assign modeTerm = mode == `MODE_T_REV || mode == `MODE_T_FWD;
  assign modeDev = mode == `MODE_D_REV || mode == `MODE_D_FWD;
  assign modeBus = mode == `MODE_B_REV || mode == `MODE_B_FWD;
  assign modeOk = modeTerm || modeDev || modeBus;
  assign fwdAction = mode[0];
  // network bit acts as if the assigned terminal were driven
  assign selOn = |(selAssigned & (inSync | commSel));
  assign pidEnable = modeOk && (selAssigned == '0 || selOn);

  // analog scaling to tenths of a percent
  function automatic pct_t scaleVolt(input logic [ADC_W-1:0] adc, input logic half);
    logic [31:0] t;
    t = 32'(adc) * 32'h3e8;
    if (half)
      t = t << 1;
    t = t >> ADC_W;
    scaleVolt = (t > 32'(`PCT_FULL)) ? `PCT_FULL : pct_t'(t[15:0]);
  endfunction : scaleVolt

  // live zero at 4 of 20 mA, below it clamps to zero
  function automatic pct_t scaleCurrent(input logic [ADC_W-1:0] adc);
    logic [31:0] off, t;
    off = (32'h1 << ADC_W) / 32'h5;
    t = 32'h0;
    if (32'(adc) > off)
      t = ((32'(adc) - off) * 32'h4e2) >> ADC_W;
    scaleCurrent = (t > 32'(`PCT_FULL)) ? `PCT_FULL : pct_t'(t[15:0]);
  endfunction : scaleCurrent

  pct_t spTerm, measTerm, spSel, measSel;
  spsrc_t spSrc;
  logic spHalf;
  assign spHalf = spRange == `SP_RANGE_5V_A || spRange == `SP_RANGE_5V_B;
  assign spTerm = scaleVolt(setpointAdc, spHalf);
  always_comb begin
    case (measRange)
      `MEAS_RANGE_MA: measTerm = scaleCurrent(measuredAdc);
      `MEAS_RANGE_5V: measTerm = scaleVolt(measuredAdc, 1'b1);
      default: measTerm = scaleVolt(measuredAdc, 1'b0);
    endcase
  end
  always_comb begin
    if (modeBus)
      spSrc = SRC_BUS;
    else if (panelSp != `PCT_NONE)
      spSrc = SRC_PANEL;
    else
      spSrc = SRC_TERMINAL;
  end
  always_comb begin
    case (spSrc)
      SRC_BUS: spSel = busSp;
      SRC_PANEL: spSel = panelSp;
      SRC_TERMINAL: spSel = spTerm;
      default: spSel = '0;
    endcase
  end
  assign measSel = modeBus ? busMeas : measTerm;

  logic signed [16:0] nextDev;
  assign nextDev = modeDev ? 17'(busDev) : 17'(spSel) - 17'(measSel);

  // control update tick
  logic [12:0] tickCnt;
  logic tick;
  assign tick = tickCnt == 13'(CTRL_CYCLES - 1);
  always_ff @(posedge mclk) begin
    if (!reset_n || tick)
      tickCnt <= '0;
    else
      tickCnt <= tickCnt + 13'h1;
  end

  // integral saturates so long runs cannot wrap
  logic signed [16:0] dev;
  logic signed [19:0] integ, next_integ, piPart, pdPart, mvRaw;
  always_comb begin
    next_integ = integ + 20'(nextDev);
    if (next_integ > 20'sh1ffff)
      next_integ = 20'sh1ffff;
    else if (next_integ < -20'sh1ffff)
      next_integ = -20'sh1ffff;
    piPart = 20'(nextDev) + (pidCfg[`CFG_INTEG] ? next_integ : 20'sh0);
    pdPart = 20'(nextDev) + (pidCfg[`CFG_DERIV] ? 20'(nextDev) - 20'(dev) : 20'sh0);
    mvRaw = piPart + pdPart;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || !pidEnable) begin
      dev <= '0;
      integ <= '0;
      freqCmd <= '0;
    end else if (tick) begin
      dev <= nextDev;
      integ <= next_integ;
      // forward action flips the sign of the correction
      freqCmd <= fwdAction ? -18'(mvRaw) : 18'(mvRaw);
    end
  end

  logic upperFlag, lowerFlag, rotFwd;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pidActive <= 1'b0;
      upperFlag <= 1'b0;
      lowerFlag <= 1'b0;
      rotFwd <= 1'b0;
    end else begin
      pidActive <= pidEnable;
      upperFlag <= upperLim != `PCT_NONE && measSel > upperLim;
      lowerFlag <= (modeTerm || modeBus) && lowerLim != `PCT_NONE && measSel < lowerLim;
      rotFwd <= runSync[0] && !runSync[1];
    end
  end

  // output terminal function map
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      logic neg, act;
      logic [7:0] base;
      assign neg = outFunc[gi] >= `OUT_FN_NEG;
      assign base = neg ? outFunc[gi] - `OUT_FN_NEG : outFunc[gi];
      always_comb begin
        case (base)
          `OUT_FN_LOWER: act = lowerFlag;
          `OUT_FN_UPPER: act = upperFlag;
          `OUT_FN_ROT: act = rotFwd;
          `OUT_FN_PID: act = pidActive;
          default: act = 1'b0;
        endcase
      end
      always_ff @(posedge mclk) begin
        if (!reset_n)
          outputTerminal[gi] <= 1'b0;
        else
          outputTerminal[gi] <= act ^ neg;
      end
      AST_OUT_INVERT: assert property (@(posedge mclk) disable iff (!reset_n)
        $stable(outFunc[gi]) && outFunc[gi] == (`OUT_FN_PID + `OUT_FN_NEG)
        |=> outputTerminal[gi] == !$past(pidActive))
        else $error("inverted pid output wrong");
    end
  endgenerate

  // sticky events, a set in the clearing cycle survives
  logic [2:0] events, clr;
  logic upperQ, lowerQ, pidQ;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      upperQ <= 1'b0;
      lowerQ <= 1'b0;
      pidQ <= 1'b0;
    end else begin
      upperQ <= upperFlag;
      lowerQ <= lowerFlag;
      pidQ <= pidActive;
    end
  end
  assign events[`ST_UPPER] = upperFlag && !upperQ;
  assign events[`ST_LOWER] = lowerFlag && !lowerQ;
  assign events[`ST_PID] = pidActive != pidQ;
  assign clr = (wrEn && paddr == `REG_STATUS) ? pwdata[2:0] : 3'h0;
  always_ff @(posedge mclk) begin
    if (!reset_n)
      status <= '0;
    else
      status <= (status & ~clr) | events;
  end
  assign irq = |(status & mask);

  // read data captured in the setup cycle
  logic [31:0] rd;
  always_comb begin
    rd = '0;
    case (paddr)
      `REG_MODE: rd = {24'h0, mode};
      `REG_PANEL_SP: rd = {16'h0, panelSp};
      `REG_RANGES: rd = {20'h0, measRange, 4'h0, spRange};
      `REG_UPPER: rd = {16'h0, upperLim};
      `REG_LOWER: rd = {16'h0, lowerLim};
      `REG_INFUNC0: for (int i = 0; i < NUM_IN && i < 4; i++) rd[i*8 +: 8] = inFunc[i];
      `REG_INFUNC1: for (int i = 4; i < NUM_IN; i++) rd[(i-4)*8 +: 8] = inFunc[i];
      `REG_OUTFUNC: for (int i = 0; i < NUM_OUT; i++) rd[i*8 +: 8] = outFunc[i];
      `REG_COMMSEL: rd = 32'(commSel);
      `REG_BUS_DEV: rd = {16'h0, busDev};
      `REG_BUS_SP: rd = {16'h0, busSp};
      `REG_BUS_MEAS: rd = {16'h0, busMeas};
      `REG_STATUS: rd = {20'h0, rotFwd, lowerFlag, upperFlag, pidActive, 5'h0, status};
      `REG_MASK: rd = {29'h0, mask};
      `REG_FREQ: rd = 32'(freqCmd);
      `REG_CFG: rd = {30'h0, pidCfg};
      default: rd = '0;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!reset_n)
      prdata <= '0;
    else if (setup)
      prdata <= rd;
  end

  AST_MODE_GATE: assert property (@(posedge mclk) disable iff (!reset_n)
    !modeOk |=> !pidActive && freqCmd == 18'sh0)
    else $error("pid active with invalid mode");
  AST_SELECT_GATE: assert property (@(posedge mclk) disable iff (!reset_n)
    selAssigned != '0 && !selOn |=> !pidActive)
    else $error("pid active with select off");
  AST_NORMAL_ZERO: assert property (@(posedge mclk) disable iff (!reset_n)
    !pidActive && !$past(pidEnable) |-> freqCmd == 18'sh0)
    else $error("frequency correction outside pid");
  AST_REVERSE: assert property (@(posedge mclk) disable iff (!reset_n)
    tick && pidEnable && !fwdAction && pidCfg == 2'h0 && nextDev > 0 |=> freqCmd == 18'(2 * $past(nextDev)))
    else $error("reverse action sign wrong");
  AST_FORWARD: assert property (@(posedge mclk) disable iff (!reset_n)
    tick && pidEnable && fwdAction && pidCfg == 2'h0 && nextDev < 0 |=> freqCmd > 0)
    else $error("forward action sign wrong");
  AST_PANEL_SP: assert property (@(posedge mclk) disable iff (!reset_n)
    modeTerm && panelSp != `PCT_NONE |-> spSel == panelSp)
    else $error("analog set point not ignored");
  AST_BUS_DEV: assert property (@(posedge mclk) disable iff (!reset_n)
    tick && pidEnable && modeDev |=> dev == 17'($past(busDev)))
    else $error("bus deviation not taken");
  AST_UPPER: assert property (@(posedge mclk) disable iff (!reset_n)
    upperLim != `PCT_NONE && measSel > upperLim |=> upperFlag)
    else $error("upper limit flag missing");
  AST_UPPER_STICKY: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(upperFlag) |=> status[`ST_UPPER])
    else $error("upper limit event not latched");
  AST_LOWER_MODE: assert property (@(posedge mclk) disable iff (!reset_n)
    !(modeTerm || modeBus) || lowerLim == `PCT_NONE |=> !lowerFlag)
    else $error("lower flag outside its modes");
  AST_ROT: assert property (@(posedge mclk) disable iff (!reset_n)
    runSync[1] |=> !rotFwd)
    else $error("rotation output high in reverse");

  COV_PID_ON: cover property (@(posedge mclk) disable iff (!reset_n) $rose(pidActive));
  COV_UPPER: cover property (@(posedge mclk) disable iff (!reset_n) $rose(upperFlag));
  COV_IRQ: cover property (@(posedge mclk) disable iff (!reset_n) $rose(irq));

endmodule : pid_process_control_selector
`default_nettype wire

// ==== process_source_model.sv ====
// detector and set-point source: analog levels reach the selector as adc codes
// assumes the bench gives the levels as codes and the adc converts once per mclk
`timescale 1ns/1ps
`default_nettype none
module process_source_model #(
  parameter int ADC_W = 10
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [ADC_W-1:0] setLevel,
  input wire logic [ADC_W-1:0] measLevel,
  output logic [ADC_W-1:0] setpointAdc,
  output logic [ADC_W-1:0] measuredAdc
);
  // a conversion takes one cycle, so a level change lands a cycle late
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      setpointAdc <= '0;
      measuredAdc <= '0;
    end else begin
      setpointAdc <= setLevel;
      measuredAdc <= measLevel;
    end
  end
endmodule : process_source_model
`default_nettype wire

// ==== tb.sv ====
// self-checking bench of the pid selector: apb register access plus pin stimulus
// assumes the defs header on the include path and a short control period
`timescale 1ns/1ps
`default_nettype none
`include "pid_selector_defs.svh"
module tb;
  import pid_selector_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] inputTerminal = '0;
  logic runForward = 1'b0;
  logic runReverse = 1'b0;
  logic [9:0] setLevel = '0;
  logic [9:0] measLevel = '0;
  logic [9:0] setpointAdc;
  logic [9:0] measuredAdc;
  logic [2:0] outputTerminal;
  logic pidActive;
  logic signed [17:0] freqCmd;
  logic irq;
  logic signed [17:0] f1;
  int errCount = 0;
  int nCompared = 0;
  int cycleCount = 0;
  localparam logic [63:0] MODES = 64'h163d3c3332151400;
  localparam logic [7:0] PIDON = 8'h7e;

  always #5 mclk = ~mclk;

  pid_process_control_selector #(.CTRL_CYCLES(4)) pid_process_control_selector_inst (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .inputTerminal(inputTerminal), .runForward(runForward), .runReverse(runReverse),
    .setpointAdc(setpointAdc), .measuredAdc(measuredAdc), .outputTerminal(outputTerminal),
    .pidActive(pidActive), .freqCmd(freqCmd), .irq(irq)
  );

  process_source_model #(.ADC_W(10)) process_source_model_inst (
    .mclk(mclk), .reset_n(reset_n), .setLevel(setLevel), .measLevel(measLevel),
    .setpointAdc(setpointAdc), .measuredAdc(measuredAdc)
  );

  task automatic results();
    if (errCount == 0 && nCompared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // a hung handshake would otherwise never end the run
  always @(posedge mclk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 8000) begin
      errCount++;
      results();
    end
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    nCompared++;
    if (g !== x) begin
      $display("mismatch %s expected %h seen %h", n, x, g);
      errCount++;
    end
  endtask : chk

  task automatic apbXfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apbXfer

  task automatic setReg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apbXfer(1'b1, a, d, q, e);
  endtask : setReg

  task automatic expReg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apbXfer(1'b0, a, 32'h0, q, e);
    chk($sformatf("reg %h", a), x, q & m);
  endtask : expReg

  task automatic chkFreq(input logic signed [17:0] x);
    chk("freqCmd", {{14{x[17]}}, x}, {{14{freqCmd[17]}}, freqCmd});
  endtask : chkFreq

  // long enough for pin sync, adc, output registers and one control tick
  task automatic settle();
    repeat (24) @(posedge mclk);
  endtask : settle

  initial begin
    logic [31:0] q;
    logic e;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    expReg(`REG_MODE, 32'hffffffff, 32'h0);
    expReg(`REG_PANEL_SP, 32'hffffffff, 32'h270f);
    expReg(`REG_RANGES, 32'hffffffff, 32'h1);
    expReg(`REG_CFG, 32'hffffffff, 32'h3);
    apbXfer(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped pslverr", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    // no select terminal assigned: the mode alone decides
    for (int i = 0; i < 8; i++) begin
      setReg(`REG_MODE, {24'h0, MODES[i*8 +: 8]});
      settle();
      chk("pidActive", {31'h0, PIDON[i]}, {31'h0, pidActive});
    end
    setReg(`REG_INFUNC0, 32'h0000000e);
    setReg(`REG_MODE, 32'h14);
    settle();
    chk("pidActive", 32'h0, {31'h0, pidActive});
    inputTerminal[0] <= 1'b1;
    settle();
    chk("pidActive", 32'h1, {31'h0, pidActive});
    inputTerminal[0] <= 1'b0;
    setReg(`REG_COMMSEL, 32'h1);
    settle();
    chk("pidActive", 32'h1, {31'h0, pidActive});
    setReg(`REG_COMMSEL, 32'h0);
    setReg(`REG_INFUNC0, 32'h0);
    // terminal 0 pid, terminal 1 inverted pid, terminal 2 rotation
    setReg(`REG_OUTFUNC, 32'h0010932f);
    runForward <= 1'b1;
    settle();
    chk("outputTerminal", 32'h5, {29'h0, outputTerminal});
    runReverse <= 1'b1;
    settle();
    chk("outputTerminal", 32'h1, {29'h0, outputTerminal});
    runForward <= 1'b0;
    runReverse <= 1'b0;
    setReg(`REG_MODE, 32'h0);
    settle();
    chk("outputTerminal", 32'h2, {29'h0, outputTerminal});
    chkFreq(18'sd0);
    // proportional only: output is twice the deviation
    setReg(`REG_CFG, 32'h0);
    setReg(`REG_RANGES, 32'h200);
    measLevel <= 10'd512;
    setReg(`REG_PANEL_SP, 32'd600);
    setReg(`REG_MODE, 32'h14);
    settle();
    chkFreq(18'sd200);
    setLevel <= 10'd1023;
    settle();
    chkFreq(18'sd200);
    setReg(`REG_MODE, 32'h15);
    settle();
    chkFreq(-18'sd200);
    setReg(`REG_MODE, 32'h14);
    setReg(`REG_PANEL_SP, 32'h270f);
    setLevel <= 10'd256;
    settle();
    chkFreq(-18'sd500);
    setReg(`REG_RANGES, 32'h201);
    settle();
    chkFreq(18'sd0);
    setReg(`REG_RANGES, 32'h000);
    setReg(`REG_PANEL_SP, 32'd600);
    measLevel <= 10'd614;
    settle();
    chkFreq(18'sd200);
    setReg(`REG_BUS_DEV, 32'd50);
    setReg(`REG_MODE, 32'h32);
    settle();
    chkFreq(18'sd100);
    setReg(`REG_BUS_SP, 32'd700);
    setReg(`REG_BUS_MEAS, 32'd400);
    setReg(`REG_MODE, 32'h3c);
    settle();
    chkFreq(18'sd600);
    // integral on: a steady deviation keeps pushing the output
    setReg(`REG_CFG, 32'h1);
    settle();
    f1 = freqCmd;
    repeat (8) @(posedge mclk);
    chk("integral growth", 32'h1, {31'h0, freqCmd > f1});
    // derivative on: a step in the measured value kicks once
    setReg(`REG_CFG, 32'h2);
    settle();
    chkFreq(18'sd600);
    setReg(`REG_BUS_MEAS, 32'd300);
    while (freqCmd == 18'sd600) @(posedge mclk);
    chkFreq(18'sd900);
    setReg(`REG_CFG, 32'h0);
    // limit flags and interrupt
    setReg(`REG_RANGES, 32'h200);
    measLevel <= 10'd100;
    setReg(`REG_UPPER, 32'd500);
    setReg(`REG_LOWER, 32'h270f);
    setReg(`REG_MODE, 32'h14);
    settle();
    setReg(`REG_STATUS, 32'h7);
    setReg(`REG_MASK, 32'h1);
    settle();
    chk("irq", 32'h0, {31'h0, irq});
    measLevel <= 10'd1023;
    settle();
    expReg(`REG_STATUS, 32'h201, 32'h201);
    chk("irq", 32'h1, {31'h0, irq});
    setReg(`REG_STATUS, 32'h1);
    settle();
    chk("irq", 32'h0, {31'h0, irq});
    setReg(`REG_LOWER, 32'd300);
    setReg(`REG_MASK, 32'h2);
    measLevel <= 10'd100;
    settle();
    expReg(`REG_STATUS, 32'h402, 32'h402);
    chk("irq", 32'h1, {31'h0, irq});
    setReg(`REG_MASK, 32'h0);
    settle();
    chk("irq", 32'h0, {31'h0, irq});
    setReg(`REG_MODE, 32'h32);
    settle();
    expReg(`REG_STATUS, 32'h400, 32'h0);
    setReg(`REG_BUS_MEAS, 32'd200);
    setReg(`REG_MODE, 32'h3d);
    settle();
    expReg(`REG_STATUS, 32'h400, 32'h400);
    results();
  end
endmodule : tb
`default_nettype wire
